/* File: rtl/etp_pkg.sv */
`default_nettype none
package etp_pkg;
  // register byte offsets
  localparam logic [7:0] ETP_RUN_OFS = 8'h00;
  localparam logic [7:0] ETP_CLKSEL_OFS = 8'h04;
  localparam logic [7:0] ETP_PINCTL_OFS = 8'h08;
  localparam logic [7:0] ETP_STATUS_OFS = 8'h0c;
  localparam logic [7:0] ETP_CMPA_OFS = 8'h10;
  localparam logic [7:0] ETP_COUNT_OFS = 8'h14;
  localparam logic [7:0] ETP_DMACTL_OFS = 8'h20;
  localparam logic [7:0] ETP_DMASRC_OFS = 8'h24;
  localparam logic [7:0] ETP_DMADST_OFS = 8'h28;
  localparam logic [7:0] ETP_DMACNT_OFS = 8'h2c;
  localparam logic [7:0] ETP_MODE_OFS = 8'h30;
  localparam logic [7:0] ETP_TRIG_OFS = 8'h34;
  localparam logic [7:0] ETP_NENH_OFS = 8'h38;
  localparam logic [7:0] ETP_NENL_OFS = 8'h3c;
  localparam logic [7:0] ETP_NDH_OFS = 8'h40;
  localparam logic [7:0] ETP_NDL_OFS = 8'h44;
  localparam logic [7:0] ETP_DIRH_OFS = 8'h48;
  localparam logic [7:0] ETP_DIRL_OFS = 8'h4c;
  localparam logic [7:0] ETP_PORTH_OFS = 8'h50;
  localparam logic [7:0] ETP_PORTL_OFS = 8'h54;
  // field positions
  localparam int ETP_RUN_BIT = 0;
  localparam int ETP_EXT_BIT = 0;
  localparam int ETP_CLR_BIT = 1;
  localparam int ETP_PIN_BIT = 0;
  localparam int ETP_MATCH_BIT = 0;
  localparam int ETP_DTE_BIT = 7;
  localparam int ETP_DIE_BIT = 3;
  localparam int ETP_INC_BIT = 1;
  localparam int ETP_WORD_BIT = 0;
  localparam int ETP_NOVL_BIT = 0;
  // i/o addresses seen by the dma channel
  localparam logic [7:0] ETP_IO_NDH = 8'ha4;
  localparam logic [7:0] ETP_IO_NDL = 8'ha5;
  // reset values and encodings
  localparam logic [15:0] ETP_CMPA_RST = 16'hffff;
  localparam logic [1:0] ETP_TRIG_TMR0 = 2'h0;
  localparam logic [1:0] ETP_RESP_OKAY = 2'h0;
  localparam logic [1:0] ETP_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ETP_DMA_IDLE = 3'b001,
    ETP_DMA_READ = 3'b010,
    ETP_DMA_WRITE = 3'b100
  } etp_dma_e;
endpackage
`default_nettype wire

/* File: rtl/etp_pattern_out.sv */
// Our own choices: the register offsets and register access over AXI4-Lite.
`default_nettype none
// Summary of operation
// [RULE1] counter clears to zero whenever it matches compare value A
// [RULE2] compare value A accepts one, giving a match on every counted edge
// [RULE3] clock select lets the counter count rising edges of the external pin
// [RULE4] compare A can run with its pin output off, giving internal events only
// [RULE5] counter advances only while its run bit is set
// [RULE6] each compare A match starts one dma transfer into next pattern data
// [RULE7] dma moves words in i/o mode, source increments, destination fixed
// [RULE8] destination at high next-data address makes one word fill both bytes
// [RULE9] software supplies a fifteen word table and programs count and start address
// [RULE10] compare match of timer zero copies next data onto the pattern pins
// [RULE11] sixteen pattern bits exist; twelve are used in the upper positions
// [RULE12] high and low groups have own next data, moved only where enabled
// [RULE13] mode selects non-overlap or normal; normal updates pins with no gap
// [RULE14] a pin drives only when its direction bit is set; port holds value
// [RULE15] software keeps a done flag at zero until its end handler sets it
// [RULE16] count reaching zero clears dma enable and, if enabled, signals end
module etp_pattern_out
  import etp_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int MADDR_W = 24
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pattern table memory read port
  output logic mem_req,
  output logic [MADDR_W-1:0] mem_addr,
  output logic mem_word,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // timer pins
  input wire logic external_count_pin,
  output logic compare_pin,
  output logic compare_pin_oe_n,
  // pattern pins
  output logic [7:0] pattern_high,
  output logic [7:0] pattern_high_oe_n,
  output logic [7:0] pattern_low,
  output logic [7:0] pattern_low_oe_n,
  // dma end event
  output logic dma_end_irq
);
  // the read mux and the merge helper carry at most one 32-bit word
  if (CNT_W < 2 || CNT_W > 32 || MADDR_W < 8 || MADDR_W > 32) begin : g_width_check
    $error("etp_pattern_out: unsupported width");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- bus slave ----------------
  logic aw_held, w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_go = ce && aw_held && w_held && !s_axi_bvalid;

  function automatic logic wr_hit(input logic go, input logic [7:0] a, input logic [7:0] ofs);
    return go && (a[7:2] == ofs[7:2]);
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // control registers written only by software
  logic run, ext_sel, clr_on_a, pin_en, novl;
  logic [1:0] trig_sel;
  logic [CNT_W-1:0] cmp_a;
  logic [7:0] nen_h, nen_l, dir_h, dir_l, dma_dst;
  logic dma_die, dma_inc, dma_word;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run <= 1'b0;
      ext_sel <= 1'b0;
      clr_on_a <= 1'b0;
      pin_en <= 1'b0;
      novl <= 1'b0;
      trig_sel <= ETP_TRIG_TMR0;
      cmp_a <= CNT_W'(ETP_CMPA_RST);
      nen_h <= 8'h00;
      nen_l <= 8'h00;
      dir_h <= 8'h00;
      dir_l <= 8'h00;
      dma_dst <= 8'h00;
      dma_die <= 1'b0;
      dma_inc <= 1'b0;
      dma_word <= 1'b0;
    end else begin
      if (wr_hit(wr_go, wr_addr, ETP_RUN_OFS) && wr_strb[0]) begin
        run <= wr_data[ETP_RUN_BIT]; // [RULE5]
      end
      if (wr_hit(wr_go, wr_addr, ETP_CLKSEL_OFS) && wr_strb[0]) begin
        ext_sel <= wr_data[ETP_EXT_BIT]; // [RULE3]
        clr_on_a <= wr_data[ETP_CLR_BIT];
      end
      if (wr_hit(wr_go, wr_addr, ETP_PINCTL_OFS) && wr_strb[0]) begin
        pin_en <= wr_data[ETP_PIN_BIT]; // [RULE4]
      end
      if (wr_hit(wr_go, wr_addr, ETP_CMPA_OFS)) begin
        cmp_a <= CNT_W'(merge(32'(cmp_a), wr_data, wr_strb)); // [RULE2]
      end
      if (wr_hit(wr_go, wr_addr, ETP_MODE_OFS) && wr_strb[0]) begin
        novl <= wr_data[ETP_NOVL_BIT]; // [RULE13]
      end
      if (wr_hit(wr_go, wr_addr, ETP_TRIG_OFS) && wr_strb[0]) begin
        trig_sel <= wr_data[1:0];
      end
      if (wr_hit(wr_go, wr_addr, ETP_NENH_OFS) && wr_strb[0]) begin
        nen_h <= wr_data[7:0]; // [RULE12]
      end
      if (wr_hit(wr_go, wr_addr, ETP_NENL_OFS) && wr_strb[0]) begin
        nen_l <= wr_data[7:0]; // [RULE12]
      end
      if (wr_hit(wr_go, wr_addr, ETP_DIRH_OFS) && wr_strb[0]) begin
        dir_h <= wr_data[7:0];
      end
      if (wr_hit(wr_go, wr_addr, ETP_DIRL_OFS) && wr_strb[0]) begin
        dir_l <= wr_data[7:0];
      end
      if (wr_hit(wr_go, wr_addr, ETP_DMADST_OFS) && wr_strb[0]) begin
        dma_dst <= wr_data[7:0]; // [RULE8]
      end
      if (wr_hit(wr_go, wr_addr, ETP_DMACTL_OFS) && wr_strb[0]) begin
        dma_die <= wr_data[ETP_DIE_BIT];
        dma_inc <= wr_data[ETP_INC_BIT];
        dma_word <= wr_data[ETP_WORD_BIT];
      end
    end
  end

  // ---------------- timer channel ----------------
  logic ext_s1, ext_s2, ext_s3;
  logic tick, match_a, match_flag;
  logic [CNT_W-1:0] count, count_inc;
  // the first stage is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else if (ce) begin
      ext_s1 <= external_count_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
  // internal source counts every enabled system cycle
  assign tick = ce && run && (ext_sel ? (ext_s2 && !ext_s3) : 1'b1); // [RULE3] [RULE5]
  assign count_inc = count + CNT_W'(1);
  assign match_a = tick && (count_inc == cmp_a);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      if (tick) begin
        count <= (match_a && clr_on_a) ? '0 : count_inc; // [RULE1]
      end else if (wr_hit(wr_go, wr_addr, ETP_COUNT_OFS)) begin
        count <= CNT_W'(merge(32'(count), wr_data, wr_strb));
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      match_flag <= 1'b0;
    end else if (ce) begin
      if (match_a) begin
        match_flag <= 1'b1;
      end else if (wr_hit(wr_go, wr_addr, ETP_STATUS_OFS) && wr_strb[0] &&
                   wr_data[ETP_MATCH_BIT]) begin
        match_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_pin <= 1'b0;
    end else if (ce && match_a && pin_en) begin
      compare_pin <= !compare_pin; // [RULE4]
    end
  end
  assign compare_pin_oe_n = !pin_en; // [RULE4]

  // ---------------- dma channel ----------------
  etp_dma_e dma_st;
  logic dma_en, dma_pend;
  logic [MADDR_W-1:0] dma_src;
  logic [15:0] dma_cnt, dma_buf;
  logic dma_wr;
  assign dma_wr = ce && (dma_st == ETP_DMA_WRITE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_st <= ETP_DMA_IDLE;
      dma_en <= 1'b0;
      dma_pend <= 1'b0;
      dma_src <= '0;
      dma_cnt <= 16'h0000;
      dma_buf <= 16'h0000;
      dma_end_irq <= 1'b0;
    end else if (ce) begin
      dma_end_irq <= 1'b0;
      // a match while a move is under way is kept for later
      if (match_a && dma_en && dma_st != ETP_DMA_IDLE) begin
        dma_pend <= 1'b1; // [RULE6]
      end else if (dma_st == ETP_DMA_IDLE) begin
        dma_pend <= 1'b0;
      end
      if (wr_hit(wr_go, wr_addr, ETP_DMACTL_OFS) && wr_strb[0]) begin
        dma_en <= wr_data[ETP_DTE_BIT];
      end
      if (wr_hit(wr_go, wr_addr, ETP_DMASRC_OFS)) begin
        dma_src <= MADDR_W'(merge(32'(dma_src), wr_data, wr_strb));
      end
      if (wr_hit(wr_go, wr_addr, ETP_DMACNT_OFS)) begin
        dma_cnt <= 16'(merge(32'(dma_cnt), wr_data, wr_strb));
      end
      unique case (dma_st)
        ETP_DMA_IDLE: begin
          if (dma_en && (match_a || dma_pend)) begin
            dma_st <= ETP_DMA_READ; // [RULE6]
          end
        end
        ETP_DMA_READ: begin
          if (mem_ack) begin
            dma_buf <= mem_rdata;
            dma_st <= ETP_DMA_WRITE;
          end
        end
        ETP_DMA_WRITE: begin
          dma_st <= ETP_DMA_IDLE;
          if (dma_inc) begin
            dma_src <= dma_src + (dma_word ? MADDR_W'(2) : MADDR_W'(1)); // [RULE7]
          end
          dma_cnt <= dma_cnt - 16'h0001;
          if (dma_cnt == 16'h0001) begin
            dma_en <= 1'b0; // [RULE16]
            dma_pend <= 1'b0;
            dma_end_irq <= dma_die; // [RULE16]
          end
        end
      endcase
    end
  end
  assign mem_req = (dma_st == ETP_DMA_READ);
  assign mem_addr = dma_src;
  assign mem_word = dma_word;

  // ---------------- pattern output ----------------
  logic [7:0] nd_h, nd_l, port_h, port_l;
  logic ptrig, gap;
  assign ptrig = match_a && (trig_sel == ETP_TRIG_TMR0); // [RULE10]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nd_h <= 8'h00;
      nd_l <= 8'h00;
    end else if (ce) begin
      if (dma_wr && dma_word && dma_dst == ETP_IO_NDH) begin
        nd_h <= dma_buf[15:8]; // [RULE8]
        nd_l <= dma_buf[7:0];
      end else if (dma_wr && !dma_word && dma_dst == ETP_IO_NDH) begin
        nd_h <= dma_buf[7:0]; // [RULE7]
      end else if (dma_wr && !dma_word && dma_dst == ETP_IO_NDL) begin
        nd_l <= dma_buf[7:0];
      end else begin
        if (wr_hit(wr_go, wr_addr, ETP_NDH_OFS) && wr_strb[0]) begin
          nd_h <= wr_data[7:0];
        end
        if (wr_hit(wr_go, wr_addr, ETP_NDL_OFS) && wr_strb[0]) begin
          nd_l <= wr_data[7:0];
        end
      end
    end
  end

  // non-overlap trades one blank cycle per change for glitch-free edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_h <= 8'h00;
      port_l <= 8'h00;
      gap <= 1'b0;
    end else if (ce) begin
      gap <= ptrig && novl; // [RULE13]
      if (ptrig) begin
        port_h <= (port_h & ~nen_h) | (nd_h & nen_h); // [RULE12] [RULE11]
        port_l <= (port_l & ~nen_l) | (nd_l & nen_l); // [RULE12] [RULE11]
      end else begin
        if (wr_hit(wr_go, wr_addr, ETP_PORTH_OFS) && wr_strb[0]) begin
          port_h <= wr_data[7:0];
        end
        if (wr_hit(wr_go, wr_addr, ETP_PORTL_OFS) && wr_strb[0]) begin
          port_l <= wr_data[7:0];
        end
      end
    end
  end
  assign pattern_high = gap ? (port_h & ~nen_h) : port_h; // [RULE13]
  assign pattern_low = gap ? (port_l & ~nen_l) : port_l;
  assign pattern_high_oe_n = ~dir_h; // [RULE14]
  assign pattern_low_oe_n = ~dir_l; // [RULE14]

  // ---------------- responses ----------------
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[7:2])
      ETP_RUN_OFS[7:2]: rd_val[ETP_RUN_BIT] = run;
      ETP_CLKSEL_OFS[7:2]: rd_val[1:0] = {clr_on_a, ext_sel};
      ETP_PINCTL_OFS[7:2]: rd_val[ETP_PIN_BIT] = pin_en;
      ETP_STATUS_OFS[7:2]: rd_val[ETP_MATCH_BIT] = match_flag;
      ETP_CMPA_OFS[7:2]: rd_val = 32'(cmp_a);
      ETP_COUNT_OFS[7:2]: rd_val = 32'(count);
      ETP_DMACTL_OFS[7:2]: rd_val[7:0] = {dma_en, 3'h0, dma_die, 1'b0, dma_inc, dma_word};
      ETP_DMASRC_OFS[7:2]: rd_val = 32'(dma_src);
      ETP_DMADST_OFS[7:2]: rd_val[7:0] = dma_dst;
      ETP_DMACNT_OFS[7:2]: rd_val[15:0] = dma_cnt;
      ETP_MODE_OFS[7:2]: rd_val[ETP_NOVL_BIT] = novl;
      ETP_TRIG_OFS[7:2]: rd_val[1:0] = trig_sel;
      ETP_NENH_OFS[7:2]: rd_val[7:0] = nen_h;
      ETP_NENL_OFS[7:2]: rd_val[7:0] = nen_l;
      ETP_NDH_OFS[7:2]: rd_val[7:0] = nd_h;
      ETP_NDL_OFS[7:2]: rd_val[7:0] = nd_l;
      ETP_DIRH_OFS[7:2]: rd_val[7:0] = dir_h;
      ETP_DIRL_OFS[7:2]: rd_val[7:0] = dir_l;
      ETP_PORTH_OFS[7:2]: rd_val[7:0] = port_h;
      ETP_PORTL_OFS[7:2]: rd_val[7:0] = port_l;
      default: rd_ok = 1'b0;
    endcase
  end

  function automatic logic mapped(input logic [7:0] a);
    return (a[7:2] <= ETP_DMACNT_OFS[7:2] && a[7:2] != 6'h06 && a[7:2] != 6'h07) ||
           (a[7:2] >= ETP_MODE_OFS[7:2] && a[7:2] <= ETP_PORTL_OFS[7:2]);
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ETP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ETP_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_addr) ? ETP_RESP_OKAY : ETP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? ETP_RESP_OKAY : ETP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/etp_pattern_out_sva.sv */
`default_nettype none
module etp_pattern_out_sva #(
  parameter int MADDR_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // table memory
  input wire logic mem_req,
  input wire logic [MADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  // pins and event
  input wire logic compare_pin,
  input wire logic compare_pin_oe_n,
  input wire logic dma_end_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_fetch_wait;
    mem_req && !mem_ack;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  a_fetch_hold: assert property (s_fetch_wait |=> mem_req && $stable(mem_addr))
    else $error("table fetch dropped or moved");
  a_one_fetch: assert property (mem_ack |=> !mem_req)
    else $error("fetch repeated after ack");
  a_end_pulse: assert property (dma_end_irq |=> !dma_end_irq)
    else $error("end event longer than one cycle");
  a_pin_quiet: assert property (compare_pin_oe_n && $past(compare_pin_oe_n) |-> $stable(compare_pin))
    else $error("compare pin moved while disabled");
endmodule
bind etp_pattern_out etp_pattern_out_sva #(.MADDR_W(MADDR_W)) etp_pattern_out_sva_inst (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .compare_pin(compare_pin), .compare_pin_oe_n(compare_pin_oe_n), .dma_end_irq(dma_end_irq)
);
`default_nettype wire

/* File: tb/etp_far_side.sv */
`default_nettype none
module etp_far_side #(
  parameter int MADDR_W = 24,
  parameter logic [23:0] TABLE_BASE = 24'h010076
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // table memory
  input wire logic mem_req,
  input wire logic [MADDR_W-1:0] mem_addr,
  input wire logic mem_word,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  input wire logic slow,
  // edge source
  output logic external_count_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pattern_table [15];
  int wait_cnt;
  int idx;
  initial begin
    for (int i = 0; i < 15; i++) begin
      pattern_table[i] = 16'((i + 1) * 16'h1110);
    end
    external_count_pin = 1'b0;
  end
  // bus not answered shows a changing pattern, so stale data cannot pass
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    idx = int'((mem_addr - MADDR_W'(TABLE_BASE)) >> 1);
    if (!rst_n) begin
      wait_cnt <= 0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack) begin
      if (wait_cnt >= (slow ? 6 : 0)) begin
        mem_ack <= 1'b1;
        mem_rdata <= (idx < 15 && mem_word) ? pattern_table[idx] : 16'h0bad;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
  task automatic edge_pulse();
    @(posedge clk);
    external_count_pin <= 1'b1;
    repeat (4) @(posedge clk);
    external_count_pin <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb
  import etp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, slow, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mem_req, mem_word, mem_ack, ext_pin;
  logic cmp_pin, cmp_oe_n, dma_end_irq, output_done_flag;
  logic [7:0] awaddr, araddr, pat_h, pat_h_oe_n, pat_l, pat_l_oe_n;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  logic [23:0] mem_addr;
  logic [15:0] mem_rdata, exp16;
  int num_errors = 0;
  int checks_done = 0;
  int irq_seen = 0;
  etp_pattern_out etp_pattern_out_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_word(mem_word), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .external_count_pin(ext_pin), .compare_pin(cmp_pin),
    .compare_pin_oe_n(cmp_oe_n), .pattern_high(pat_h), .pattern_high_oe_n(pat_h_oe_n),
    .pattern_low(pat_l), .pattern_low_oe_n(pat_l_oe_n), .dma_end_irq(dma_end_irq));
  etp_far_side etp_far_side_inst (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_word(mem_word), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .slow(slow), .external_count_pin(ext_pin));
  always #2.5 clk = ~clk;
  // software side keeps the done flag low until the end event
  always @(posedge clk) begin
    if (!rst_n) begin
      output_done_flag <= 1'b0;
    end else if (dma_end_irq === 1'b1) begin
      irq_seen <= irq_seen + 1;
      output_done_flag <= 1'b1;
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("BAD %0t bus timeout", $time);
    test_done();
  endtask
  // readiness is sampled at the falling edge; it cannot change before the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tv;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tv = bvalid;
      wr_resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tv) break;
    end
    bready <= 1'b0;
    if (n == 100) hang();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic ta, tv;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tv = rvalid;
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tv) break;
    end
    rready <= 1'b0;
    if (n == 100) hang();
  endtask
  task automatic reset_values();
    chk(pat_h_oe_n, 8'hff);
    axi_rd(ETP_CMPA_OFS);
    chk(rd_data, 32'h0000ffff);
    axi_rd(8'h18);
    chk(rd_resp, ETP_RESP_SLVERR);
    axi_wr(8'h18, 32'h1);
    chk(wr_resp, ETP_RESP_SLVERR);
  endtask
  task automatic main_flow();
    axi_wr(ETP_CMPA_OFS, 32'h1);
    axi_wr(ETP_CLKSEL_OFS, 32'h3);
    axi_wr(ETP_PINCTL_OFS, 32'h0);
    axi_wr(ETP_DMASRC_OFS, 32'h010076);
    axi_wr(ETP_DMADST_OFS, 32'(ETP_IO_NDH));
    axi_wr(ETP_DMACNT_OFS, 32'd15);
    axi_wr(ETP_DMACTL_OFS, 32'h8b);
    axi_wr(ETP_MODE_OFS, 32'h0);
    axi_wr(ETP_TRIG_OFS, 32'(ETP_TRIG_TMR0));
    axi_wr(ETP_NENH_OFS, 32'hff);
    axi_wr(ETP_NENL_OFS, 32'hf0);
    axi_wr(ETP_NDH_OFS, 32'h5a);
    axi_wr(ETP_NDL_OFS, 32'ha5);
    axi_wr(ETP_PORTL_OFS, 32'h0c);
    axi_wr(ETP_DIRH_OFS, 32'hff);
    axi_wr(ETP_DIRL_OFS, 32'hf0);
    chk({pat_h_oe_n, pat_l_oe_n}, 16'h000f);
    axi_wr(ETP_RUN_OFS, 32'h1);
    for (int k = 1; k <= 16; k++) begin
      slow <= k[0];
      etp_far_side_inst.edge_pulse();
      exp16 = (k == 1) ? 16'h5aa5 : 16'((k - 1) * 16'h1110);
      chk(pat_h, exp16[15:8]);
      chk(pat_l, {exp16[7:4], 4'hc});
      if (k == 14) chk(output_done_flag, 1'b0);
    end
    chk(irq_seen, 1);
    chk(output_done_flag, 1'b1);
    axi_rd(ETP_DMACTL_OFS);
    chk(rd_data, 32'h0b);
    axi_rd(ETP_DMASRC_OFS);
    chk(rd_data, 32'h010076 + 32'd30);
    axi_rd(ETP_DMADST_OFS);
    chk(rd_data, 32'(ETP_IO_NDH));
  endtask
  task automatic count_stop();
    axi_wr(ETP_CMPA_OFS, 32'h3);
    repeat (2) etp_far_side_inst.edge_pulse();
    axi_rd(ETP_COUNT_OFS);
    chk(rd_data, 32'h2);
    etp_far_side_inst.edge_pulse();
    axi_rd(ETP_COUNT_OFS);
    chk(rd_data, 32'h0);
    axi_wr(ETP_RUN_OFS, 32'h0);
    etp_far_side_inst.edge_pulse();
    axi_rd(ETP_COUNT_OFS);
    chk(rd_data, 32'h0);
  endtask
  // non-overlap blanks enabled bits for one cycle; the compare pin toggles once
  task automatic gap_pin();
    int zeros;
    zeros = 0;
    axi_wr(ETP_CMPA_OFS, 32'h1);
    axi_wr(ETP_PINCTL_OFS, 32'h1);
    axi_wr(ETP_MODE_OFS, 32'h1);
    axi_wr(ETP_NDH_OFS, 32'h3c);
    axi_wr(ETP_RUN_OFS, 32'h1);
    chk(cmp_oe_n, 1'b0);
    fork
      etp_far_side_inst.edge_pulse();
      repeat (24) begin
        @(negedge clk);
        if (pat_h == 8'h00) zeros++;
      end
    join
    chk(zeros, 1);
    chk(pat_h, 8'h3c);
    chk(cmp_pin, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    slow = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    reset_values();
    main_flow();
    count_stop();
    gap_pin();
    test_done();
  end
endmodule
`default_nettype wire
